// ### verilog/lanc_defs.svh
// constants for the level adjust and digital sound config register bank
`ifndef LANC_DEFS_SVH
`define LANC_DEFS_SVH
`define LANC_SUB_CH1 8'h0c
`define LANC_SUB_CH2 8'h0d
`define LANC_SUB_CFG 8'h0e
`define LANC_RST_VAL 8'h00
`define LANC_GAIN_NEG_BIT 4
`define LANC_CFG_PULL 7
`define LANC_CFG_TEST 6
`define LANC_CFG_DOUT 4
`define LANC_CFG_SRC 2
`define LANC_CFG_DEEM 1
`define LANC_CFG_AUTOMUTE_DISABLE 0
`define LANC_CFG_WMASK 8'hd7
`define LANC_GAIN_WMASK 8'h1f
`endif

// ### verilog/lanc_pkg.sv
// types for the level adjust and digital sound config register bank
`default_nettype none
package lanc_pkg;
	typedef enum logic [1:0] {
		LANC_SRC_NICAM = 2'b00,
		LANC_SRC_CARRIER1 = 2'b01,
		LANC_SRC_ANALOG_MONO = 2'b10
	} lanc_src_t;
	typedef logic signed [4:0] lanc_db_t;
endpackage
`default_nettype wire

// ### verilog/lanc_regs.sv
// register bank: fm level gains and digital sound configuration
//==========================================================
// Function
// [RULE_01] ch1 level reg at 12, resets 0dB
// [RULE_02] gain code: bit4 sign, undefined 11111
// [RULE_03] ch1 gain also feeds mono path
// [RULE_04] ch2 level reg at 13, same code
// [RULE_05] host sets equal gains for stereo/dual
// [RULE_06] config reg at 14, resets zero
// [RULE_07] host writes zero to bits 5,3
// [RULE_08] pull bit picks low/high test frequency
// [RULE_09] osc test only in fm mode
// [RULE_10] host avoids osc test in normal use
// [RULE_11] stream out enable drives or floats pins
// [RULE_12] source select: analog mono or carrier1
// [RULE_13] source select needs automute and dac path
// [RULE_14] serial audio fallback always carrier1
// [RULE_15] bypass bit skips j17 de-emphasis
// [RULE_16] automute follows error rate unless disabled
// [RULE_17] automute only with nicam second carrier
// [RULE_18] host sets mono or auto dematrix
// [RULE_19] host decides whether automute allowed
// [RULE_20] error hysteresis between upper, lower limits
// [RULE_21] auto dematrix uses identification result
// [RULE_22] writes act next clock edge
`timescale 1ns/1ps
`default_nettype none
`include "lanc_defs.svh"
module lanc_regs
	import lanc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic [7:0] wr_sub,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_sub,
	output logic [7:0] rd_data,
	input wire logic fm_mode,
	input wire logic carrier2_nicam,
	input wire logic dac_path_sel,
	input wire logic [7:0] bit_err_cnt,
	input wire logic [7:0] error_upper_limit,
	input wire logic [7:0] error_lower_limit,
	input wire logic auto_dematrix_switch,
	input wire logic [2:0] manual_dematrix,
	input wire logic [2:0] ident_dematrix,
	input wire logic nicam_data_in,
	input wire logic nicam_clk_in,
	output logic signed [4:0] ch1_gain_db,
	output logic signed [4:0] ch2_gain_db,
	output logic signed [4:0] mono_gain_db,
	output logic ch1_gain_undef,
	output logic ch2_gain_undef,
	output logic osc_test_enable,
	output logic osc_pull_low,
	output logic deemph_bypass,
	output logic nicam_fail_r,
	output logic [1:0] analog_src,
	output logic [1:0] serial_audio_src,
	output logic [2:0] dematrix_sel,
	output logic serial_data_o,
	output logic serial_data_oe_n,
	output logic serial_clk_o,
	output logic serial_clk_oe_n
);
	//==========================================================
	// registers
	logic [7:0] channel1_level_gain_r, channel2_level_gain_r, digital_sound_config_r;
	logic fail_nxt;
	logic automute_on;
	logic hit_ch1, hit_ch2, hit_cfg;
	logic data_s1_r, data_s2_r, clk_s1_r, clk_s2_r;

	// ones' complement style code to dB; undefined code 11111 gives 0 dB
	function automatic lanc_db_t code_to_db(input logic [7:0] code);
		if (code[`LANC_GAIN_NEG_BIT]) begin
			code_to_db = lanc_db_t'({1'b0, code[3:0]}) - 5'sd15; // [RULE_02]
		end else begin
			code_to_db = lanc_db_t'({1'b0, code[3:0]});
		end
	endfunction

	// subaddress hits of the strobe; any other subaddress leaves the bank alone
	assign hit_ch1 = wr_en && (wr_sub == `LANC_SUB_CH1);
	assign hit_ch2 = wr_en && (wr_sub == `LANC_SUB_CH2);
	assign hit_cfg = wr_en && (wr_sub == `LANC_SUB_CFG);

	// writes land on the clock edge of the write strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			channel1_level_gain_r <= `LANC_RST_VAL; // [RULE_01]
			channel2_level_gain_r <= `LANC_RST_VAL; // [RULE_04]
			digital_sound_config_r <= `LANC_RST_VAL; // [RULE_06]
		end else begin
			if (hit_ch1) channel1_level_gain_r <= wr_data & `LANC_GAIN_WMASK; // [RULE_22]
			if (hit_ch2) channel2_level_gain_r <= wr_data & `LANC_GAIN_WMASK;
			if (hit_cfg) digital_sound_config_r <= wr_data & `LANC_CFG_WMASK;
		end
	end

	// readback; unused bits read zero so reserved writes cannot stick
	assign rd_data = (rd_sub == `LANC_SUB_CH1) ? channel1_level_gain_r :
		(rd_sub == `LANC_SUB_CH2) ? channel2_level_gain_r :
		(rd_sub == `LANC_SUB_CFG) ? digital_sound_config_r : 8'h00;

	//==========================================================
	// gains
	assign ch1_gain_db = code_to_db(channel1_level_gain_r); // [RULE_01]
	assign mono_gain_db = ch1_gain_db; // [RULE_03]
	assign ch2_gain_db = code_to_db(channel2_level_gain_r); // [RULE_04]
	assign ch1_gain_undef = channel1_level_gain_r[4:0] == 5'h1f; // [RULE_02]
	assign ch2_gain_undef = channel2_level_gain_r[4:0] == 5'h1f;

	//==========================================================
	// oscillator test, gated to fm mode
	assign osc_test_enable = digital_sound_config_r[`LANC_CFG_TEST] & fm_mode; // [RULE_09]
	assign osc_pull_low = osc_test_enable & digital_sound_config_r[`LANC_CFG_PULL]; // [RULE_08]
	assign deemph_bypass = digital_sound_config_r[`LANC_CFG_DEEM]; // [RULE_15]

	//==========================================================
	// automute with hysteresis; count is same-domain logic, not synchronised
	assign automute_on = ~digital_sound_config_r[`LANC_CFG_AUTOMUTE_DISABLE] & carrier2_nicam; // [RULE_17]
	assign fail_nxt = !automute_on ? 1'b0 :
		(bit_err_cnt > error_upper_limit) ? 1'b1 :
		(bit_err_cnt < error_lower_limit) ? 1'b0 : nicam_fail_r; // [RULE_20]
	always_ff @(posedge clk) begin
		if (sys_rst) nicam_fail_r <= 1'b0;
		else nicam_fail_r <= fail_nxt; // [RULE_16]
	end
	assign analog_src = !nicam_fail_r ? LANC_SRC_NICAM :
		(digital_sound_config_r[`LANC_CFG_SRC] & dac_path_sel) ? LANC_SRC_ANALOG_MONO :
		LANC_SRC_CARRIER1; // [RULE_12] [RULE_13]
	assign serial_audio_src = nicam_fail_r ? LANC_SRC_CARRIER1 : LANC_SRC_NICAM; // [RULE_14]
	assign dematrix_sel = auto_dematrix_switch ? ident_dematrix : manual_dematrix; // [RULE_21]

	//==========================================================
	// serial stream pins: two-flop sync, enables low while driving
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_s1_r <= 1'b0;
			data_s2_r <= 1'b0;
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
		end else begin
			data_s1_r <= nicam_data_in;
			data_s2_r <= data_s1_r;
			clk_s1_r <= nicam_clk_in;
			clk_s2_r <= clk_s1_r;
		end
	end
	assign serial_data_o = data_s2_r;
	assign serial_clk_o = clk_s2_r;
	assign serial_data_oe_n = ~digital_sound_config_r[`LANC_CFG_DOUT]; // [RULE_11]
	assign serial_clk_oe_n = ~digital_sound_config_r[`LANC_CFG_DOUT];

	//==========================================================
	// checks
	// steps of the error count; while automute is on, the fallback only moves outside the hysteresis band
	sequence s_err_high;
		automute_on && bit_err_cnt > error_upper_limit;
	endsequence
	sequence s_err_band;
		automute_on && !(bit_err_cnt > error_upper_limit) && !(bit_err_cnt < error_lower_limit);
	endsequence
	sequence s_err_low;
		automute_on && !(bit_err_cnt > error_upper_limit) && bit_err_cnt < error_lower_limit;
	endsequence
	a_ch1_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_01]
		wr_en && wr_sub == `LANC_SUB_CH1 |=> channel1_level_gain_r == ($past(wr_data) & 8'h1f))
		else $error("ch1 write lost");
	a_gain_map: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_02]
		channel1_level_gain_r == 8'h10 |-> ch1_gain_db == -5'sd15)
		else $error("gain map wrong");
	a_gain_pos: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_02]
		!channel1_level_gain_r[4] |-> ch1_gain_db == $signed({1'b0, channel1_level_gain_r[3:0]}))
		else $error("positive gain wrong");
	a_gain_neg: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_02]
		channel1_level_gain_r[4] && channel1_level_gain_r[3:0] != 4'hf |-> ch1_gain_db < 5'sd0)
		else $error("negative gain wrong");
	a_mono_gain: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_03]
		mono_gain_db == ch1_gain_db)
		else $error("mono gain differs");
	a_ch2_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_04]
		wr_en && wr_sub == `LANC_SUB_CH2 |=> ch2_gain_db == code_to_db($past(wr_data) & 8'h1f))
		else $error("ch2 write lost");
	a_cfg_reset: assert property (@(posedge clk) // [RULE_06]
		$past(sys_rst) |-> digital_sound_config_r == 8'h00)
		else $error("config not reset");
	a_cfg_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_22]
		wr_en && wr_sub == `LANC_SUB_CFG |=> digital_sound_config_r == ($past(wr_data) & 8'hd7))
		else $error("config write lost");
	a_pull_low: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_08]
		osc_pull_low |-> fm_mode && digital_sound_config_r[7:6] == 2'b11)
		else $error("pull without test");
	a_osc_fm: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
		!fm_mode |-> !osc_test_enable)
		else $error("test outside fm");
	a_pins_float: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_11]
		!digital_sound_config_r[4] |-> serial_data_oe_n && serial_clk_oe_n)
		else $error("pins driven");
	a_src_mono: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_12]
		nicam_fail_r && digital_sound_config_r[2] && dac_path_sel |-> analog_src == LANC_SRC_ANALOG_MONO)
		else $error("mono source missed");
	a_src_sel: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_13]
		nicam_fail_r && !dac_path_sel |-> analog_src == LANC_SRC_CARRIER1)
		else $error("source bad");
	a_serial_src: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_14]
		serial_audio_src != LANC_SRC_ANALOG_MONO)
		else $error("serial fallback bad");
	a_deemph_bypass: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_15]
		deemph_bypass == digital_sound_config_r[1])
		else $error("deemph bad");
	a_mute_fail: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_20]
		s_err_high |=> nicam_fail_r)
		else $error("no fallback");
	a_mute_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_20]
		s_err_high ##1 s_err_band |=> nicam_fail_r)
		else $error("fallback dropped in band");
	a_mute_return: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_20]
		s_err_low |=> !nicam_fail_r)
		else $error("no return to digital sound");
	a_mute_off: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_17]
		!carrier2_nicam |=> !nicam_fail_r)
		else $error("mute w/o nicam");
	a_mute_dis: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_16]
		digital_sound_config_r[0] |=> !nicam_fail_r)
		else $error("mute when disabled");
	a_dematrix_select: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_21]
		auto_dematrix_switch |-> dematrix_sel == ident_dematrix)
		else $error("dematrix bad");
endmodule // lanc_regs
`default_nettype wire

// ### verification/lanc_host.sv
// host controller model that writes the register bank by subaddress
`timescale 1ns/1ps
`default_nettype none
`include "lanc_defs.svh"
module lanc_host (
	input wire logic clk,
	output logic wr_en,
	output logic [7:0] wr_sub,
	output logic [7:0] wr_data
);
	//==========================================================
	// write cycle
	// one strobe cycle per write; idle data is inverted so a stale byte never looks valid
	initial begin
		wr_en = 1'b0;
		wr_sub = 8'h00;
		wr_data = 8'h00;
	end
	// gain pairing, test mode and automute policy are left to the caller
	task automatic put(input logic [7:0] sub, input logic [7:0] data);
		@(posedge clk) #1;
		wr_en = 1'b1;
		wr_sub = sub;
		wr_data = (sub == `LANC_SUB_CFG) ? (data & `LANC_CFG_WMASK) : data;
		@(posedge clk) #1;
		wr_en = 1'b0;
		wr_data = ~wr_data;
	endtask
endmodule // lanc_host
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the level gain and digital sound config registers
`timescale 1ns/1ps
`default_nettype none
`include "lanc_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench import lanc_pkg::*; ;
	logic clk, sys_rst, wr_en, fm, c2n, dac, ads, nd, nc, u1, u2, ot, op, db, nf;
	logic sdo, sdoe, sco, scoe;
	logic [7:0] wr_sub, wr_data, rd_sub, rd_data, cnt, up, lo;
	logic [2:0] man, idn, dsel;
	logic [1:0] asrc, ssrc;
	logic signed [4:0] g1, g2, gm;
	logic [31:0] rs;
	int fail_count, tests_run, cyc, m_cfg;
	//==========================================================
	// model helpers
	function automatic logic [31:0] nxt(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// undefined code reads as 0 dB by the designer's choice
	function automatic logic signed [4:0] gexp(input logic [4:0] c);
		return (c == 5'h1f) ? 5'sd0 : c[4] ? 5'(int'(c[3:0]) - 15) : 5'(c[3:0]);
	endfunction
	lanc_host i_host (.clk(clk), .wr_en(wr_en), .wr_sub(wr_sub), .wr_data(wr_data));
	lanc_regs i_dut (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en), .wr_sub(wr_sub),
		.wr_data(wr_data), .rd_sub(rd_sub), .rd_data(rd_data), .fm_mode(fm),
		.carrier2_nicam(c2n), .dac_path_sel(dac), .bit_err_cnt(cnt), .error_upper_limit(up),
		.error_lower_limit(lo), .auto_dematrix_switch(ads), .manual_dematrix(man),
		.ident_dematrix(idn), .nicam_data_in(nd), .nicam_clk_in(nc), .ch1_gain_db(g1),
		.ch2_gain_db(g2), .mono_gain_db(gm), .ch1_gain_undef(u1), .ch2_gain_undef(u2),
		.osc_test_enable(ot), .osc_pull_low(op), .deemph_bypass(db), .nicam_fail_r(nf),
		.analog_src(asrc), .serial_audio_src(ssrc), .dematrix_sel(dsel), .serial_data_o(sdo),
		.serial_data_oe_n(sdoe), .serial_clk_o(sco), .serial_clk_oe_n(scoe));
	//==========================================================
	// clock, timeout and verdict
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic give_verdict();
		$display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// generous ceiling; the sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	//==========================================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		{fm, c2n, dac, ads, nd, nc, man, idn, rd_sub, cnt} = '0;
		up = 8'h50;
		lo = 8'h14;
		rs = 32'h2860d374;
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		for (int s = 12; s < 16; s++) begin
			rd_sub = 8'(s);
			#1 `CHK(rd_data, `LANC_RST_VAL)
		end
		`CHK({sdoe, scoe, nf, asrc}, 5'b11000)
		$display("test reset done");
		// every gain code, junk in bits 7..5
		for (int c = 0; c < 32; c++) begin
			rs = nxt(rs);
			i_host.put(`LANC_SUB_CH1, {rs[7:5], 5'(c)});
			i_host.put(`LANC_SUB_CH2, {rs[10:8], 5'(31 - c)});
			rd_sub = `LANC_SUB_CH1;
			#1 `CHK(rd_data, {3'h0, 5'(c)})
			`CHK({g1, gm, u1}, {gexp(5'(c)), gexp(5'(c)), c == 31})
			`CHK({g2, u2}, {gexp(5'(31 - c)), c == 0})
		end
		i_host.put(8'h0f, 8'h55);
		rd_sub = 8'h0f;
		#1 `CHK({rd_data, g1}, {8'h00, gexp(5'h00)})
		// fm stereo style reception: the host gives both channels one code
		fm = 1'b1;
		rs = nxt(rs);
		i_host.put(`LANC_SUB_CH1, {4'h0, rs[3:0] | 4'h1});
		i_host.put(`LANC_SUB_CH2, {4'h0, rs[3:0] | 4'h1});
		#1 `CHK({g1, g2}, {gexp({1'b0, rs[3:0] | 4'h1}), gexp({1'b0, rs[3:0] | 4'h1})})
		$display("test gains done");
		// test mode bits are only randomised here, outside normal operation
		for (int i = 0; i < 40; i++) begin
			rs = nxt(rs);
			{fm, c2n, dac, ads, man, idn} = rs[19:10];
			i_host.put(`LANC_SUB_CFG, rs[7:0]);
			m_cfg = rs[7:0] & `LANC_CFG_WMASK;
			rd_sub = `LANC_SUB_CFG;
			#1 `CHK(rd_data, 8'(m_cfg))
			`CHK({ot, op}, {fm & m_cfg[6], fm & m_cfg[6] & m_cfg[7]})
			`CHK({db, sdoe, scoe}, {m_cfg[1], !m_cfg[4], !m_cfg[4]})
			`CHK(dsel, ads ? idn : man)
		end
		$display("test config done");
		// error count hysteresis for both source selects and dac paths
		ads = 1'b1;
		for (int k = 0; k < 4; k++) begin
			c2n = 1'b1;
			dac = k[0];
			cnt = 8'h00;
			i_host.put(`LANC_SUB_CFG, {5'h00, k[1], 2'b00});
			cnt = up + 8'h01;
			@(posedge clk) #1 `CHK({nf, asrc, ssrc}, {1'b1, (k == 3) ? 2'd2 : 2'd1, 2'd1})
			cnt = lo;
			@(posedge clk) #1 `CHK(nf, 1'b1)
			cnt = lo - 8'h01;
			@(posedge clk) #1 `CHK({nf, asrc, ssrc}, 5'b00000)
		end
		for (int k = 0; k < 2; k++) begin
			c2n = k[0];
			cnt = 8'hff;
			i_host.put(`LANC_SUB_CFG, {7'h00, k[0]});
			repeat (2) @(posedge clk);
			#1 `CHK(nf, 1'b0)
		end
		$display("test automute done");
		i_host.put(`LANC_SUB_CFG, 8'h10);
		for (int i = 0; i < 8; i++) begin
			rs = nxt(rs);
			{nd, nc} = rs[1:0];
			repeat (4) @(posedge clk);
			#1 `CHK({sdo, sco, sdoe, scoe}, {nd, nc, 2'b00})
		end
		// reset in mid-run clears the bank again
		sys_rst = 1'b1;
		@(posedge clk) #1 sys_rst = 1'b0;
		rd_sub = `LANC_SUB_CFG;
		#1 `CHK({rd_data, sdoe}, {`LANC_RST_VAL, 1'b1})
		`CHK({g1, g2, nf}, {10'h000, 1'b0})
		$display("test serial and reset done");
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
